// *** src/bsef_top.sv ***
// Purpose: status and error flag registers of a serial display link master bridge, apb slave
// Assumes: link events are levels sampled at rising link clock edges; link clock far slower than pclk
// Notes:   word registers on a 32-bit apb; upper half of every word reads zero
//
// Functional notes
// - status bit 15: command buffer empty
// - status bit 14: command buffer not full
// - status bit 11: clock lane in stop state
// - status bit 10: data lane in stop state
// - status bit 7: pll locked
// - status bit 6: low power timer not expired
// - status bit 5: high speed timer not expired
// - status bit 4: acknowledge trigger received
// - status bit 3: any acknowledge response received
// - status bit 2: slave returned lane ownership
// - status bit 1: ready for more packet data
// - status bit 0: read data available
// - error register sixteen bits, resets to zero
// - crc and ecc error flags, write-one clear
// - error bit 2: lane contention occurred
// - error bit 0: virtual channel mismatch
`include "bsef_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bsef_top #(
  parameter int unsigned CMD_DEPTH = `BSEF_CMD_DEPTH,  // command buffer capacity in packets
  parameter int unsigned LVL_W     = 5                 // width of the occupancy count
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`BSEF_ADDR_W-1:0]    paddr,
  input  wire logic [`BSEF_DATA_W-1:0]    pwdata,
  output logic      [`BSEF_DATA_W-1:0]    prdata,
  output logic                            pready,
  output logic                            pslverr,
  // link side, asynchronous to pclk
  input  wire logic                       link_clk,
  input  wire bsef_pkg::bsef_link_evt_t   link_evt,
  input  wire bsef_pkg::bsef_lane_t       lane_state,
  input  wire logic                       pll_lock_raw,
  // logic on pclk
  input  wire logic [LVL_W-1:0]           cmd_buf_level,
  input  wire bsef_pkg::bsef_local_t      local_stat,
  // outputs
  output logic                            error_check_disable,
  output logic                            irq
);

  // ---------------------------------------------------------------
  // crossing from the link and pll domains
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_W = 12;         // clock, 8 events, 2 lanes, pll lock
  localparam logic [SYNC_W-1:0] SYNC_INIT = 12'h006; // lanes idle in stop state

  logic [SYNC_W-1:0] sync_in;                  // raw bundle
  logic [SYNC_W-1:0] sync_out;                 // filtered bundle
  logic              link_clk_s;               // filtered link clock
  bsef_pkg::bsef_link_evt_t evt_s;             // filtered event levels
  bsef_pkg::bsef_lane_t     lane_s;            // filtered lane levels
  logic              pll_lock_s;               // filtered lock
  logic              link_clk_prev_q;          // link clock one pclk ago
  logic              link_rise;                // rising link clock edge seen

  // events and clock pass the same chain, so their relative timing is kept
  assign sync_in = {link_clk, link_evt, lane_state, pll_lock_raw};

  bsef_sync #(
    .WIDTH (SYNC_W),
    .INIT  (SYNC_INIT)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  assign link_clk_s = sync_out[11];
  assign evt_s      = bsef_pkg::bsef_link_evt_t'(sync_out[10:3]);
  assign lane_s     = bsef_pkg::bsef_lane_t'(sync_out[2:1]);
  assign pll_lock_s = sync_out[0];

  // edge finder on the filtered link clock; a stopped link clock simply gives no edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_clk_prev_q <= 1'b0;
    end else begin
      link_clk_prev_q <= link_clk_s;
    end
  end

  assign link_rise = link_clk_s & ~link_clk_prev_q;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic       setup;          // first cycle of a transfer
  logic       done;           // completing access cycle
  logic       wr_done;        // completing write
  logic [9:0] idx;            // word index of the access
  logic       hit_status;     // interrupt status register
  logic       hit_error;      // error status register
  logic       hit_st_mask;    // status interrupt mask
  logic       hit_er_mask;    // error interrupt mask
  logic       hit_ctrl;       // control register
  logic       hit_any;        // some register decoded
  logic [15:0] wdata;         // low half of write data

  assign setup   = psel & ~penable;
  assign done    = psel & penable & pready;
  assign wr_done = done & pwrite & ~pslverr;
  assign idx     = paddr[`BSEF_ADDR_W-1:2];
  assign wdata   = pwdata[15:0];

  // address decode
  always_comb begin
    hit_status  = 1'b0;
    hit_error   = 1'b0;
    hit_st_mask = 1'b0;
    hit_er_mask = 1'b0;
    hit_ctrl    = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      // misaligned access maps to nothing
    end else if (idx == `BSEF_IDX_STATUS) begin
      hit_status = 1'b1;
    end else if (idx == `BSEF_IDX_ERROR) begin
      hit_error = 1'b1;
    end else if (idx == `BSEF_IDX_STAT_MASK) begin
      hit_st_mask = 1'b1;
    end else if (idx == `BSEF_IDX_ERR_MASK) begin
      hit_er_mask = 1'b1;
    end else if (idx == `BSEF_IDX_CTRL) begin
      hit_ctrl = 1'b1;
    end
  end

  assign hit_any = hit_status | hit_error | hit_st_mask | hit_er_mask | hit_ctrl;

  // ---------------------------------------------------------------
  // control and mask registers
  // ---------------------------------------------------------------
  logic [15:0] st_mask_q;   // interrupt enables, status layout
  logic [15:0] er_mask_q;   // interrupt enables, error layout
  logic [15:0] ctrl_q;      // control word

  // software writes, taken only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_mask_q <= `BSEF_MASK_RESET;
      er_mask_q <= `BSEF_MASK_RESET;
      ctrl_q    <= `BSEF_CTRL_RESET;
    end else begin
      if (wr_done && hit_st_mask) begin
        st_mask_q <= wdata;
      end
      if (wr_done && hit_er_mask) begin
        er_mask_q <= wdata & `BSEF_ERR_STK_MASK;
      end
      if (wr_done && hit_ctrl) begin
        ctrl_q <= wdata & `BSEF_CTRL_WR_MASK;
      end
    end
  end

  // disable bit also drives the receive checkers directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_check_disable <= 1'b0;
    end else begin
      error_check_disable <= (wr_done && hit_ctrl) ? wdata[`BSEF_CTRL_ECD] : ctrl_q[`BSEF_CTRL_ECD];
    end
  end

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  logic        ecd;         // checking disabled
  logic [2:0]  st_set;      // acknowledge trigger, any acknowledge, turnaround
  logic [2:0]  st_clr;      // write-one clear for those
  logic [2:0]  st_flag;     // stored status flags
  logic [5:0]  er_set;      // crc, ecc2, ecc1, overflow, contention, vc mismatch
  logic [5:0]  er_clr;      // write-one clear for those
  logic [5:0]  er_flag;     // stored error flags

  assign ecd = ctrl_q[`BSEF_CTRL_ECD];

  // events from the link count once, at the rising link clock edge
  assign st_set[2] = link_rise & evt_s.ack_trig;
  assign st_set[1] = link_rise & (evt_s.ack_trig | evt_s.ack_err_rpt);
  assign st_set[0] = link_rise & evt_s.turnaround;

  assign st_clr = {wdata[`BSEF_ST_ACK_TRIG], wdata[`BSEF_ST_ACK_RESP], wdata[`BSEF_ST_TURN]}
                  & {3{wr_done & hit_status}};

  bsef_sticky #(
    .WIDTH (3),
    .INIT  (`BSEF_ST_STK_RESET)
  ) u_st_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .set_in  (st_set),
    .clr_in  (st_clr),
    .flag_q  (st_flag)
  );

  // crc and ecc checks only count while checking is enabled
  assign er_set[5] = link_rise & evt_s.crc_err & ~ecd;
  assign er_set[4] = link_rise & evt_s.ecc_multi_err & ~ecd;
  assign er_set[3] = link_rise & evt_s.ecc_single_err & ~ecd;
  assign er_set[2] = local_stat.cmd_buf_overflow;
  assign er_set[1] = link_rise & evt_s.contention;
  assign er_set[0] = link_rise & evt_s.vc_mismatch;

  assign er_clr = {wdata[`BSEF_ER_CRC], wdata[`BSEF_ER_ECC_MULTI], wdata[`BSEF_ER_ECC_SINGLE],
                   wdata[`BSEF_ER_CMD_OVF], wdata[`BSEF_ER_CONTENTION], wdata[`BSEF_ER_VC_MISMATCH]}
                  & {6{wr_done & hit_error}};

  // all error flags start at zero
  bsef_sticky #(
    .WIDTH (6),
    .INIT  (`BSEF_ERR_RESET)
  ) u_er_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .set_in  (er_set),
    .clr_in  (er_clr),
    .flag_q  (er_flag)
  );

  // ---------------------------------------------------------------
  // read words
  // ---------------------------------------------------------------
  logic [15:0] status_word;  // interrupt status as read
  logic [15:0] error_word;   // error status as read
  logic [15:0] rd_word;      // selected register

  // compose status; unlisted bits stay zero
  always_comb begin
    status_word = 16'h0000;
    status_word[`BSEF_ST_CMD_EMPTY] = (cmd_buf_level == '0);
    status_word[`BSEF_ST_CMD_ROOM]  = (32'(cmd_buf_level) < CMD_DEPTH);
    status_word[`BSEF_ST_CLK_STOP]  = lane_s.clk_lane_stop_state;
    status_word[`BSEF_ST_DATA_STOP] = lane_s.data_lane_stop_state;
    status_word[`BSEF_ST_PLL_LOCK]  = pll_lock_s;
    status_word[`BSEF_ST_LP_LIVE]   = ~local_stat.lp_rx_timer_expired;
    status_word[`BSEF_ST_HS_LIVE]   = ~local_stat.hs_tx_timer_expired;
    status_word[`BSEF_ST_ACK_TRIG]  = st_flag[2];
    status_word[`BSEF_ST_ACK_RESP]  = st_flag[1];
    status_word[`BSEF_ST_TURN]      = st_flag[0];
    status_word[`BSEF_ST_PKT_READY] = local_stat.packet_accept_ready;
    status_word[`BSEF_ST_RD_AVAIL]  = local_stat.read_data_available;
  end

  // compose error status; reserved positions read zero
  always_comb begin
    error_word = 16'h0000;
    error_word[`BSEF_ER_CRC]         = er_flag[5];
    error_word[`BSEF_ER_ECC_MULTI]   = er_flag[4];
    error_word[`BSEF_ER_ECC_SINGLE]  = er_flag[3];
    error_word[`BSEF_ER_CMD_OVF]     = er_flag[2];
    error_word[`BSEF_ER_CONTENTION]  = er_flag[1];
    error_word[`BSEF_ER_VC_MISMATCH] = er_flag[0];
  end

  // read mux
  always_comb begin
    rd_word = 16'h0000;
    if (hit_status) begin
      rd_word = status_word;
    end else if (hit_error) begin
      rd_word = error_word;
    end else if (hit_st_mask) begin
      rd_word = st_mask_q;
    end else if (hit_er_mask) begin
      rd_word = er_mask_q;
    end else if (hit_ctrl) begin
      rd_word = ctrl_q;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: one wait-free access cycle after setup
  // ---------------------------------------------------------------
  // the slave always answers in the first access cycle; slow hosts before lock are their own concern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= ~hit_any;
      prdata  <= pwrite ? '0 : {16'h0000, rd_word};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt: level, high while any enabled flag is set
  // ---------------------------------------------------------------
  // live status bits may be enabled too, which lets software wait on buffer space or lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(status_word & st_mask_q)) | (|(error_word & er_mask_q));
    end
  end

endmodule : bsef_top
`default_nettype wire

// *** src/bsef_consts.svh ***
// Purpose: offsets, field positions, reset values and writable masks of the bridge status and error flag bank
// Assumes: included by bare name from src/ files
// Notes:   offsets are word indices; the byte address on the bus is four times the index
`ifndef BSEF_CONSTS_SVH
`define BSEF_CONSTS_SVH

// bus geometry
`define BSEF_ADDR_W         12
`define BSEF_DATA_W         32
`define BSEF_REG_W          16

// register word indices (byte address = index * 4)
`define BSEF_IDX_STATUS     10'h0c6
`define BSEF_IDX_ERROR      10'h0c7
`define BSEF_IDX_STAT_MASK  10'h0d0
`define BSEF_IDX_ERR_MASK   10'h0d1
`define BSEF_IDX_CTRL       10'h0d2

// interrupt status field positions
`define BSEF_ST_CMD_EMPTY   15
`define BSEF_ST_CMD_ROOM    14
`define BSEF_ST_CLK_STOP    11
`define BSEF_ST_DATA_STOP   10
`define BSEF_ST_PLL_LOCK    7
`define BSEF_ST_LP_LIVE     6
`define BSEF_ST_HS_LIVE     5
`define BSEF_ST_ACK_TRIG    4
`define BSEF_ST_ACK_RESP    3
`define BSEF_ST_TURN        2
`define BSEF_ST_PKT_READY   1
`define BSEF_ST_RD_AVAIL    0

// error status field positions
`define BSEF_ER_CRC         10
`define BSEF_ER_ECC_MULTI   9
`define BSEF_ER_ECC_SINGLE  8
`define BSEF_ER_CMD_OVF     7
`define BSEF_ER_CONTENTION  2
`define BSEF_ER_VC_MISMATCH 0

// control field positions
`define BSEF_CTRL_ECD       0

// reset values and writable masks
`define BSEF_MASK_RESET     16'h0000
`define BSEF_CTRL_RESET     16'h0000
`define BSEF_ERR_RESET      6'h00
`define BSEF_ST_STK_RESET   3'h0
`define BSEF_ERR_STK_MASK   16'h0785
`define BSEF_CTRL_WR_MASK   16'h0001

// command buffer depth in packets
`define BSEF_CMD_DEPTH      16

`endif

// *** src/bsef_pkg.sv ***
// Purpose: types shared by the bridge status and error flag bank
// Assumes: nothing beyond the constants header
// Notes:   one packed struct per group of signals that travel together
package bsef_pkg;

  // events reported by the link receiver, valid at a rising link clock edge
  typedef struct packed {
    logic crc_err;        // crc failure in a received packet
    logic ecc_multi_err;  // uncorrectable header ecc
    logic ecc_single_err; // corrected header ecc
    logic ack_trig;       // acknowledge trigger message received
    logic ack_err_rpt;    // acknowledge with error report received
    logic turnaround;     // slave handed lane ownership back
    logic contention;     // data lane contention detected
    logic vc_mismatch;    // virtual channel id differs from the one sent
  } bsef_link_evt_t;

  // link lane levels
  typedef struct packed {
    logic clk_lane_stop_state;  // clock lane in lp-11
    logic data_lane_stop_state; // data lane in lp-11
  } bsef_lane_t;

  // status from logic on pclk
  typedef struct packed {
    logic lp_rx_timer_expired;  // low power receive timer ran out
    logic hs_tx_timer_expired;  // high speed transmit timer ran out
    logic packet_accept_ready;  // bridge takes more packet data
    logic read_data_available;  // received data waiting for the host
    logic cmd_buf_overflow;     // one-cycle pulse, buffer overrun
  } bsef_local_t;

endpackage : bsef_pkg

// *** src/bsef_sync.sv ***
// Purpose: three flip-flop synchroniser with agreement filter for signals from outside pclk
// Assumes: inputs may change at any time relative to pclk
// Notes:   a change is accepted only once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module bsef_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q; // metastable stage, read only by s2_q
  logic [WIDTH-1:0] s2_q; // second stage
  logic [WIDTH-1:0] s3_q; // third stage

  // shift chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // filtered output moves per bit only on agreement, so a single odd sample is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= INIT;
    end else begin
      sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
    end
  end

endmodule : bsef_sync
`default_nettype wire

// *** src/bsef_sticky.sv ***
// Purpose: bank of sticky flags, set by hardware events, cleared by writing one
// Assumes: set and clear are single pclk cycle strobes
// Notes:   a set in the same cycle as a clear wins, so no event is lost
`timescale 1ns/1ps
`default_nettype none
module bsef_sticky #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] flag_q
);

  // set dominates clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= INIT;
    end else begin
      flag_q <= set_in | (flag_q & ~clr_in);
    end
  end

endmodule : bsef_sticky
`default_nettype wire

// *** testbench/bsef_props.sv ***
// Purpose: port level checks of the status and error flag bank
// Assumes: zero wait apb, live status bits taken at the setup edge
// Notes:   bound into bsef_top after the module
`include "bsef_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bsef_props #(
  parameter int unsigned CMD_DEPTH = 16,
  parameter int unsigned LVL_W     = 5
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pll_lock_raw,
  input wire bsef_pkg::bsef_lane_t  lane_state,
  input wire logic [LVL_W-1:0]      cmd_buf_level,
  input wire bsef_pkg::bsef_local_t local_stat,
  input wire logic                  error_check_disable
);
  // cycles since reset; synchronisers need a few before async levels show
  logic [3:0] up_q;
  wire st_rd = psel && !penable && !pwrite && paddr == {`BSEF_IDX_STATUS, 2'b00};
  wire er_rd = psel && !penable && !pwrite && paddr == {`BSEF_IDX_ERROR, 2'b00};
  wire ct_wr = psel && penable && pready && pwrite && paddr == {`BSEF_IDX_CTRL, 2'b00};

  // saturating age counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 4'h0;
    else if (up_q != 4'hf) up_q <= up_q + 4'h1;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_empty_bit: assert property (st_rd |=> prdata[15] == ($past(cmd_buf_level) == 0))
    else $error("empty bit wrong");
  chk_room_bit: assert property (st_rd |=> prdata[14] == ($past(cmd_buf_level) < CMD_DEPTH))
    else $error("room bit wrong");
  chk_timer_bits: assert property (st_rd |=> prdata[6:5] ==
    ~{$past(local_stat.lp_rx_timer_expired), $past(local_stat.hs_tx_timer_expired)})
    else $error("timer bits wrong");
  chk_ready_bits: assert property (st_rd |=> prdata[1:0] ==
    {$past(local_stat.packet_accept_ready), $past(local_stat.read_data_available)})
    else $error("ready bits wrong");
  chk_status_rsvd: assert property (st_rd |=> prdata[31:16] == 0 && prdata[13:12] == 0 && prdata[9:8] == 0)
    else $error("status reserved bits set");
  chk_error_rsvd: assert property (er_rd |=> (prdata & 32'hfffff87a) == 0)
    else $error("error reserved bits set");
  chk_lock_bit: assert property ((up_q == 4'hf && $stable(pll_lock_raw))[*8] ##0 st_rd
    |=> prdata[7] == $past(pll_lock_raw)) else $error("lock bit wrong");
  chk_lane_bits: assert property ((up_q == 4'hf && $stable(lane_state))[*8] ##0 st_rd
    |=> prdata[11:10] == $past(lane_state)) else $error("lane bits wrong");
  chk_disable_copy: assert property (ct_wr |=> error_check_disable == $past(pwdata[0]))
    else $error("check disable not copied");
  chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
endmodule : bsef_props
bind bsef_top bsef_props #(.CMD_DEPTH(CMD_DEPTH), .LVL_W(LVL_W)) props_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pll_lock_raw(pll_lock_raw),
  .lane_state(lane_state), .cmd_buf_level(cmd_buf_level), .local_stat(local_stat),
  .error_check_disable(error_check_disable));
`default_nettype wire

// *** testbench/bsef_link_far.sv ***
// Purpose: far end of the link, sends event frames on its own clock
// Assumes: clock stands still between frames
// Notes:   half period 62.5 ns keeps it out of phase with pclk
`timescale 1ns/1ps
`default_nettype none
module bsef_link_far (
  output logic                     link_clk,
  output bsef_pkg::bsef_link_evt_t link_evt
);
  initial begin
    link_clk = 1'b0;
    link_evt = '0;
  end
  // two link cycles; only the first rising edge carries the event
  task automatic send(input bsef_pkg::bsef_link_evt_t ev);
    link_evt = ev;
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
    link_evt = '0;
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
    link_evt = ~ev; // no edge follows, so stale levels must never be taken
  endtask : send
endmodule : bsef_link_far
`default_nettype wire

// *** testbench/bridge_status_and_error_flags_test.sv ***
// Purpose: self-checking bench of the status and error flag bank
// Assumes: zero wait apb slave, link events via the far end model
// Notes:   random status levels from an lfsr with fixed start
`include "bsef_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bridge_status_and_error_flags_test;
  localparam logic [11:0] A_ST = {`BSEF_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_ER = {`BSEF_IDX_ERROR, 2'b00};
  localparam logic [11:0] A_EM = {`BSEF_IDX_ERR_MASK, 2'b00};
  localparam logic [11:0] A_SM = {`BSEF_IDX_STAT_MASK, 2'b00};
  localparam logic [11:0] A_CT = {`BSEF_IDX_CTRL, 2'b00};
  logic                     pclk, presetn, psel, penable, pwrite, pll_lock_raw;
  logic                     link_clk, pready, pslverr, ecd, irq, err;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, rd, lf;
  logic [4:0]               lvl;
  logic [2:0]               stk;  // expected sticky status bits 4..2
  logic [15:0]              eexp; // expected error flags
  bsef_pkg::bsef_link_evt_t link_evt;
  bsef_pkg::bsef_lane_t     lanes;
  bsef_pkg::bsef_local_t    loc;
  int                       failures, n_tests, cyc;

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  bsef_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .link_evt(link_evt), .lane_state(lanes), .pll_lock_raw(pll_lock_raw),
    .cmd_buf_level(lvl), .local_stat(loc), .error_check_disable(ecd), .irq(irq));
  bsef_link_far link_u (.link_clk(link_clk), .link_evt(link_evt));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : nxt

  // expected status word from the levels the bench drives
  function automatic logic [31:0] exp_st();
    return {16'h0, lvl == 0, lvl < `BSEF_CMD_DEPTH, 2'b00, lanes, 2'b00, pll_lock_raw,
      ~loc.lp_rx_timer_expired, ~loc.hs_tx_timer_expired, stk, loc.packet_accept_ready,
      loc.read_data_available};
  endfunction : exp_st

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    if (!pll_lock_raw) repeat (3) @(posedge pclk); // slow host until lock
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait until pready is sampled high; only the bench timeout ends a wait that never sees it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // link event, then time for the synchroniser
  task automatic ev(input logic [7:0] e);
    link_u.send(e);
    repeat (10) @(posedge pclk);
  endtask : ev

  task automatic conclude();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // hang guard, far above the thousand or so cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, pll_lock_raw} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    lanes = 2'b11;
    lvl = 5'h0;
    loc = '0;
    stk = 3'h0;
    lf = 32'heb99ce27;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_ER, 32'h0);
    chk(rd, 32'h0);
    // random levels, corners of the buffer count first, no lock early
    for (int i = 0; i < 24; i++) begin
      lf = nxt(lf);
      @(posedge pclk);
      lvl <= (i == 0) ? 5'd0 : (i == 1) ? 5'd15 : (i == 2) ? 5'd16 : 5'(lf[4:0] % 17);
      loc <= {lf[8:5], 1'b0};
      lanes <= lf[10:9];
      pll_lock_raw <= (i > 3) & lf[11];
      repeat (8) @(posedge pclk);
      apb(1'b0, A_ST, 32'h0);
      chk(rd, exp_st());
      chk(err, 32'h0);
    end
    // every link event alone, then write-one clear
    for (int i = 0; i < 8; i++) begin
      ev(8'h01 << i);
      stk = {i == 4, i == 3 || i == 4, i == 2};
      eexp = {5'h0, i == 7, i == 6, i == 5, 5'h0, i == 1, 1'b0, i == 0};
      apb(1'b0, A_ST, 32'h0);
      chk(rd & 32'h1c, {27'h0, stk, 2'b00});
      apb(1'b0, A_ER, 32'h0);
      chk(rd, {16'h0, eexp});
      apb(1'b1, A_ST, 32'hffff);
      apb(1'b1, A_ER, 32'hffff);
      stk = 3'h0;
      apb(1'b0, A_ST, 32'h0);
      chk(rd & 32'h1c, 32'h0);
      apb(1'b0, A_ER, 32'h0);
      chk(rd, 32'h0);
    end
    // checking disabled: crc and ecc events are dropped
    apb(1'b1, A_CT, 32'h1);
    @(posedge pclk);
    chk(ecd, 32'h1);
    ev(8'he0);
    apb(1'b0, A_ER, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, A_CT, 32'h0);
    @(posedge pclk);
    chk(ecd, 32'h0);
    // interrupt from the overflow pulse: raise, mask, unmask, clear
    apb(1'b1, A_EM, 32'h0785);
    loc.cmd_buf_overflow <= 1'b1;
    @(posedge pclk);
    loc.cmd_buf_overflow <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(irq, 32'h1);
    apb(1'b0, A_ER, 32'h0);
    chk(rd, 32'h80);
    apb(1'b1, A_EM, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    apb(1'b1, A_EM, 32'h80);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    apb(1'b1, A_ER, 32'h80);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    // live status bit through the status mask
    loc <= '0;
    apb(1'b1, A_SM, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    loc.read_data_available <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(irq, 32'h1);
    apb(1'b0, A_SM, 32'h0);
    chk(rd, 32'h1);
    // unmapped address is refused
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk(err, 32'h1);
    conclude();
  end
endmodule : bridge_status_and_error_flags_test
`default_nettype wire
